//--- hdl/pll_cfg_pkg.sv
// Field positions, register offsets and post-divider table for the decoder
package pll_cfg_pkg;
  localparam int CFG_W = 128;
  localparam int REF_W = 8;
  localparam int FB_W = 11;
  localparam int FB_A_W = 3;
  localparam int FB_M_W = 8;
  localparam int CODE_W = 4;
  localparam int RATIO_W = 6;
  localparam int PATHS = 4;

  localparam int REF1_LSB = 0;
  localparam int REF2_LSB = 24;
  localparam int REF3_S0_LSB = 48;
  localparam int REF3_S1_LSB = 72;
  localparam int FB1_LSB = 8;
  localparam int FB2_LSB = 32;
  localparam int FB3_S0_LSB = 56;
  localparam int OUT1_LSB = 96;
  localparam int OUT2_LSB = 100;
  localparam int OUT3_S0_LSB = 104;
  localparam int OUT3_S1_LSB = 112;
  localparam int OUT4_S0_LSB = 108;
  localparam int OUT4_S1_LSB = 116;
  localparam int PD4_BIT = 123;

  localparam logic [4:0] CFG0_OFS = 5'h00;
  localparam logic [4:0] CFG1_OFS = 5'h04;
  localparam logic [4:0] CFG2_OFS = 5'h08;
  localparam logic [4:0] CFG3_OFS = 5'h0c;
  localparam logic [4:0] STAT_REF_OFS = 5'h10;
  localparam logic [4:0] STAT_FB_OFS = 5'h14;
  localparam logic [4:0] STAT_OUT_OFS = 5'h18;
  localparam logic [CFG_W-1:0] CFG_RST = 128'h0;

  // Code to division ratio of a post divider
  function automatic logic [RATIO_W-1:0] post_ratio(
    input logic [CODE_W-1:0] code
  );
    case (code)
      4'h0: post_ratio = 6'h01;
      4'h1: post_ratio = 6'h02;
      4'h2: post_ratio = 6'h03;
      4'h3: post_ratio = 6'h04;
      4'h4: post_ratio = 6'h05;
      4'h5: post_ratio = 6'h06;
      4'h6: post_ratio = 6'h08;
      4'h7: post_ratio = 6'h09;
      4'h8: post_ratio = 6'h0a;
      4'h9: post_ratio = 6'h0c;
      4'ha: post_ratio = 6'h0f;
      4'hb: post_ratio = 6'h10;
      4'hc: post_ratio = 6'h12;
      4'hd: post_ratio = 6'h14;
      4'he: post_ratio = 6'h19;
      default: post_ratio = 6'h32;
    endcase
  endfunction : post_ratio
endpackage : pll_cfg_pkg

//--- hdl/level_sync.sv
// Two-flop synchroniser for an asynchronous pin level
module level_sync (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta;

  // Only the second flop is read downstream
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      meta <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : level_sync

//--- hdl/post_divider.sv
// One post divider: passes one of every N source ticks
module post_divider #(
  parameter int RATIO_W = pll_cfg_pkg::RATIO_W
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [RATIO_W-1:0] ratio_i,
  input wire logic power_down_i,
  input wire logic src_tick_i,
  output logic tick_o
);
  logic [RATIO_W-1:0] count;
  logic [RATIO_W-1:0] next_count;
  logic next_tick;

  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    if (power_down_i)
    begin
      next_count = '0;
    end
    else if (src_tick_i)
    begin
      // >= keeps a shrinking ratio from running the count past its end
      if (count >= ratio_i - 1'b1)
      begin
        next_count = '0;
        next_tick = 1'b1;
      end
      else
      begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      count <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

  // Checking aid: source ticks between output ticks
  logic [7:0] gap;
  logic clean;
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      gap <= 8'h00;
      clean <= 1'b0;
    end
    else
    begin
      gap <= (tick_o ? 8'h00 : gap) + {7'h00, src_tick_i};
      if (power_down_i || (ratio_i != $past(ratio_i)))
        clean <= 1'b0;
      else if (tick_o)
        clean <= 1'b1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  div_ratio_a: assert property (
    tick_o && clean && $stable(ratio_i) |-> gap == {2'b00, ratio_i})
    else $error("post divider spacing differs from ratio");
  div_off_a: assert property (
    power_down_i |=> !tick_o ##0 count == '0)
    else $error("powered-off divider still counts");
  div_restart_a: assert property (
    $fell(power_down_i) && !src_tick_i |-> count == '0)
    else $error("divider did not restart after power-on");
endmodule : post_divider

//--- hdl/pll_divider_config_decode.sv
// Configuration word store and divider field decode with post dividers
// How it works
// - PLL1 reference divider is bits 7:0; PLL2 reference divider is 31:24.
// - PLL3 reference divider is bits 55:48 on select low, 79:72 on high.
// - PLL1 feedback divider setting is bits 18:8.
// - Feedback setting low three bits are A count, upper eight M count.
// - PLL2 feedback divider setting is bits 42:32.
// - PLL3 feedback divider setting is bits 66:56 on either select.
// - Path1 post code is bits 99:96; path2 post code is 103:100.
// - Path3 post code is 107:104 on select low, 115:112 on high.
// - Path4 post code is 111:108 on select low, 119:116 on high.
// - Codes 0 to 7 divide by 1,2,3,4,5,6,8,9.
// - Codes 8 to 15 divide by 10,12,15,16,18,20,25,50.
// - Bit 123 set powers off the path4 post divider.
module pll_divider_config_decode (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic param_set_select_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [3:0] src_tick_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [7:0] ref_div_pll1_o,
  output logic [7:0] ref_div_pll2_o,
  output logic [7:0] ref_div_pll3_o,
  output logic [2:0] fb_a_pll1_o,
  output logic [7:0] fb_m_pll1_o,
  output logic [2:0] fb_a_pll2_o,
  output logic [7:0] fb_m_pll2_o,
  output logic [2:0] fb_a_pll3_o,
  output logic [7:0] fb_m_pll3_o,
  output logic [3:0] out_tick_o
);
  localparam int W = pll_cfg_pkg::CFG_W;
  localparam int RW = pll_cfg_pkg::RATIO_W;
  localparam int CW = pll_cfg_pkg::CODE_W;

  logic param_set_select;
  logic [W-1:0] cfg;
  logic [W-1:0] next_cfg;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic bus_take;
  // Decode state sits up here because the status read below returns it
  logic [CW-1:0] code [pll_cfg_pkg::PATHS];
  logic [CW-1:0] next_code [pll_cfg_pkg::PATHS];
  logic [RW-1:0] ratio [pll_cfg_pkg::PATHS];
  logic pd4;
  logic next_pd4;
  logic [7:0] next_ref1;
  logic [7:0] next_ref2;
  logic [7:0] next_ref3;
  logic [10:0] next_fb1;
  logic [10:0] next_fb2;
  logic [10:0] next_fb3;

  level_sync u_sel_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i(param_set_select_i),
    .sync_o(param_set_select)
  );

  // Byte-lane merge of a bus write into one configuration word
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] lanes
  );
    merge_lanes = old_word;
    for (int b = 0; b < 4; b++)
      if (lanes[b])
        merge_lanes[b*8 +: 8] = new_word[b*8 +: 8];
  endfunction : merge_lanes

  // Bus: answer one cycle after a request is seen, then rest a cycle
  assign bus_take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

  always_comb
  begin
    next_cfg = cfg;
    if (bus_take && avs_write_i)
    begin
      if (avs_address_i == pll_cfg_pkg::CFG0_OFS)
        next_cfg[31:0] = merge_lanes(cfg[31:0], avs_writedata_i,
                                     avs_byteenable_i);
      else if (avs_address_i == pll_cfg_pkg::CFG1_OFS)
        next_cfg[63:32] = merge_lanes(cfg[63:32], avs_writedata_i,
                                      avs_byteenable_i);
      else if (avs_address_i == pll_cfg_pkg::CFG2_OFS)
        next_cfg[95:64] = merge_lanes(cfg[95:64], avs_writedata_i,
                                      avs_byteenable_i);
      else if (avs_address_i == pll_cfg_pkg::CFG3_OFS)
        next_cfg[127:96] = merge_lanes(cfg[127:96], avs_writedata_i,
                                       avs_byteenable_i);
    end
  end

  always_comb
  begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata_o;
    if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
    begin
      next_waitrequest = 1'b0;
      // Unmapped and write-only answers read as zero
      next_readdata = 32'h0000_0000;
      if (avs_read_i)
      begin
        if (avs_address_i == pll_cfg_pkg::CFG0_OFS)
          next_readdata = cfg[31:0];
        else if (avs_address_i == pll_cfg_pkg::CFG1_OFS)
          next_readdata = cfg[63:32];
        else if (avs_address_i == pll_cfg_pkg::CFG2_OFS)
          next_readdata = cfg[95:64];
        else if (avs_address_i == pll_cfg_pkg::CFG3_OFS)
          next_readdata = cfg[127:96];
        else if (avs_address_i == pll_cfg_pkg::STAT_REF_OFS)
          next_readdata = {7'h00, param_set_select, ref_div_pll3_o,
                           ref_div_pll2_o, ref_div_pll1_o};
        else if (avs_address_i == pll_cfg_pkg::STAT_FB_OFS)
          next_readdata = {10'h000, fb_m_pll2_o, fb_a_pll2_o,
                           fb_m_pll1_o, fb_a_pll1_o};
        else if (avs_address_i == pll_cfg_pkg::STAT_OUT_OFS)
          next_readdata = {fb_m_pll3_o, fb_a_pll3_o, 4'h0, pd4,
                           code[3], code[2], code[1], code[0]};
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      cfg <= pll_cfg_pkg::CFG_RST;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      cfg <= next_cfg;
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o <= next_readdata;
    end
  end

  // Decode; every set-dependent field is steered by one synced select,
  // so all of them flip on the same edge

  always_comb
  begin
    next_ref1 = cfg[pll_cfg_pkg::REF1_LSB +: pll_cfg_pkg::REF_W];
    next_ref2 = cfg[pll_cfg_pkg::REF2_LSB +: pll_cfg_pkg::REF_W];
    next_fb1 = cfg[pll_cfg_pkg::FB1_LSB +: pll_cfg_pkg::FB_W];
    next_fb2 = cfg[pll_cfg_pkg::FB2_LSB +: pll_cfg_pkg::FB_W];
    next_fb3 = cfg[pll_cfg_pkg::FB3_S0_LSB +: pll_cfg_pkg::FB_W];
    next_code[0] = cfg[pll_cfg_pkg::OUT1_LSB +: CW];
    next_code[1] = cfg[pll_cfg_pkg::OUT2_LSB +: CW];
    if (param_set_select)
    begin
      next_ref3 = cfg[pll_cfg_pkg::REF3_S1_LSB +:
                      pll_cfg_pkg::REF_W];
      next_code[2] = cfg[pll_cfg_pkg::OUT3_S1_LSB +: CW];
      next_code[3] = cfg[pll_cfg_pkg::OUT4_S1_LSB +: CW];
    end
    else
    begin
      next_ref3 = cfg[pll_cfg_pkg::REF3_S0_LSB +:
                      pll_cfg_pkg::REF_W];
      next_code[2] = cfg[pll_cfg_pkg::OUT3_S0_LSB +: CW];
      next_code[3] = cfg[pll_cfg_pkg::OUT4_S0_LSB +: CW];
    end
    next_pd4 = cfg[pll_cfg_pkg::PD4_BIT];
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      ref_div_pll1_o <= 8'h00;
      ref_div_pll2_o <= 8'h00;
      ref_div_pll3_o <= 8'h00;
      {fb_m_pll1_o, fb_a_pll1_o} <= 11'h000;
      {fb_m_pll2_o, fb_a_pll2_o} <= 11'h000;
      {fb_m_pll3_o, fb_a_pll3_o} <= 11'h000;
      for (int p = 0; p < pll_cfg_pkg::PATHS; p++)
        code[p] <= 4'h0;
      pd4 <= 1'b0;
    end
    else
    begin
      ref_div_pll1_o <= next_ref1;
      ref_div_pll2_o <= next_ref2;
      ref_div_pll3_o <= next_ref3;
      // Low three bits count A, upper eight count M
      {fb_m_pll1_o, fb_a_pll1_o} <= next_fb1;
      {fb_m_pll2_o, fb_a_pll2_o} <= next_fb2;
      {fb_m_pll3_o, fb_a_pll3_o} <= next_fb3;
      for (int p = 0; p < pll_cfg_pkg::PATHS; p++)
        code[p] <= next_code[p];
      pd4 <= next_pd4;
    end
  end

  // Only path4 has a power-down; the rest run whenever ticks arrive
  generate
    for (genvar g = 0; g < pll_cfg_pkg::PATHS; g++)
    begin : g_path
      assign ratio[g] = pll_cfg_pkg::post_ratio(code[g]);
      post_divider #(
        .RATIO_W(RW)
      ) u_div (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ratio_i(ratio[g]),
        .power_down_i((g == 3) ? pd4 : 1'b0),
        .src_tick_i(src_tick_i[g]),
        .tick_o(out_tick_o[g])
      );
    end
  endgenerate

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  ref_pll12_a: assert property ($stable(cfg) |->
    ref_div_pll1_o == cfg[7:0] && ref_div_pll2_o == cfg[31:24])
    else $error("PLL1 or PLL2 reference divider wrong");
  ref_pll3_a: assert property (
    $stable(cfg) && $stable(param_set_select) |->
    ref_div_pll3_o == (param_set_select ? cfg[79:72] : cfg[55:48]))
    else $error("PLL3 reference divider wrong");
  fb_pll1_a: assert property ($stable(cfg) |->
    fb_a_pll1_o == cfg[10:8] && fb_m_pll1_o == cfg[18:11])
    else $error("PLL1 feedback split wrong");
  fb_pll23_a: assert property ($stable(cfg) |->
    {fb_m_pll2_o, fb_a_pll2_o} == cfg[42:32] &&
    fb_a_pll3_o == cfg[58:56] && fb_m_pll3_o == cfg[66:59])
    else $error("PLL2 or PLL3 feedback divider wrong");
  fb3_fixed_a: assert property (
    $stable(cfg) && $changed(param_set_select) |->
    {fb_m_pll3_o, fb_a_pll3_o} == cfg[66:56])
    else $error("PLL3 feedback followed the select pin");
  code_ab_a: assert property ($stable(cfg) |->
    code[0] == cfg[99:96] && code[1] == cfg[103:100])
    else $error("path1 or path2 code wrong");
  code_cd_a: assert property (
    $stable(cfg) && $stable(param_set_select) |->
    code[2] == (param_set_select ? cfg[115:112] : cfg[107:104]) &&
    code[3] == (param_set_select ? cfg[119:116] : cfg[111:108]))
    else $error("path3 or path4 code wrong");
  // Table spot checks: a slipped row in the ratio function shows here
  ratio_low_a: assert property (
    code[0] == 4'h6 |-> ratio[0] == 6'h08)
    else $error("ratio of code 6 wrong");
  ratio_high_a: assert property (
    code[0] == 4'he |-> ratio[0] == 6'h19)
    else $error("ratio of code 14 wrong");
  pd_path4_a: assert property (
    cfg[123] && $past(cfg[123]) |=> !out_tick_o[3])
    else $error("path4 ticks while powered off");
  pd4_follow_a: assert property (
    $stable(cfg) |-> pd4 == cfg[123])
    else $error("path4 power-down does not follow its bit");
  set_switch_a: assert property (
    $changed(param_set_select) ##1
    ($stable(cfg) && $stable(param_set_select)) |->
    (param_set_select ? (ref_div_pll3_o == cfg[79:72] &&
      code[2] == cfg[115:112] && code[3] == cfg[119:116])
    : (ref_div_pll3_o == cfg[55:48] &&
      code[2] == cfg[107:104] && code[3] == cfg[111:108])))
    else $error("selected set mixed after switch");
  bus_ack_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");
  bus_write_a: assert property (
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hf &&
    avs_address_i == pll_cfg_pkg::CFG3_OFS
    |=> cfg[127:96] == $past(avs_writedata_i))
    else $error("configuration write lost");
  bus_rest_a: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("bus answered without a request");
  read_data_a: assert property (
    avs_read_i && avs_waitrequest_o && avs_address_i == pll_cfg_pkg::CFG0_OFS
    |=> avs_readdata_o == $past(cfg[31:0]))
    else $error("configuration word read back wrong");
  unmapped_a: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i > pll_cfg_pkg::CFG3_OFS
    |=> $stable(cfg))
    else $error("write outside the words changed configuration");

  sel_flip_c: cover property ($changed(param_set_select));
  write_c: cover property (avs_write_i && !avs_waitrequest_o);
  pd_on_c: cover property ($rose(pd4) ##[1:20] $fell(pd4));
  read_c: cover property (avs_read_i && !avs_waitrequest_o);
  tick_c: cover property (out_tick_o[3] && code[3] == 4'hf);
endmodule : pll_divider_config_decode

//--- bench/tb_pll_divider_config_decode.sv
// Self-checking testbench for the divider configuration decoder
module tb_pll_divider_config_decode;
  timeunit 1ns;
  timeprecision 1ns;

  // Expected ratios per post-divider code, kept apart from the design table
  localparam logic [5:0] RATIO [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0f, 6'h10, 6'h12, 6'h14, 6'h19,
    6'h32};

  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic param_set_select_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [3:0] src_tick_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] ref_div_pll1_o;
  logic [7:0] ref_div_pll2_o;
  logic [7:0] ref_div_pll3_o;
  logic [2:0] fb_a_pll1_o;
  logic [7:0] fb_m_pll1_o;
  logic [2:0] fb_a_pll2_o;
  logic [7:0] fb_m_pll2_o;
  logic [2:0] fb_a_pll3_o;
  logic [7:0] fb_m_pll3_o;
  logic [3:0] out_tick_o;
  logic [127:0] cfg = 128'h0;
  int fails = 0;
  int compares = 0;
  int tick_cnt [4];
  int snap [4];

  pll_divider_config_decode uut (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .param_set_select_i(param_set_select_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .src_tick_i(src_tick_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .ref_div_pll1_o(ref_div_pll1_o),
    .ref_div_pll2_o(ref_div_pll2_o),
    .ref_div_pll3_o(ref_div_pll3_o),
    .fb_a_pll1_o(fb_a_pll1_o),
    .fb_m_pll1_o(fb_m_pll1_o),
    .fb_a_pll2_o(fb_a_pll2_o),
    .fb_m_pll2_o(fb_m_pll2_o),
    .fb_a_pll3_o(fb_a_pll3_o),
    .fb_m_pll3_o(fb_m_pll3_o),
    .out_tick_o(out_tick_o)
  );

  initial
  begin
    forever #20 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    for (int i = 0; i < 4; i++)
      if (out_tick_o[i] === 1'b1)
        tick_cnt[i]++;
  end

  task automatic give_verdict;
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // The request stands until waitrequest is sampled low at a rising edge;
  // read data are taken at that edge, and no latency is assumed
  task automatic av_xfer(input logic wr_en, input logic [4:0] a,
                         input logic [31:0] d, input logic [3:0] be,
                         output logic [31:0] rd);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr_en;
    avs_read_i <= ~wr_en;
    do
      @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : av_xfer

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] rd;
    av_xfer(1'b1, a, d, be, rd);
    if (a < 5'h10)
      for (int b = 0; b < 4; b++)
        if (be[b])
          cfg[32 * a[3:2] + 8 * b +: 8] = d[8 * b +: 8];
  endtask : wr

  task automatic rd_chk(input string name, input logic [4:0] a,
                        input logic [31:0] exp);
    logic [31:0] rd;
    av_xfer(1'b0, a, 32'h0, 4'hf, rd);
    chk(name, exp, rd);
  endtask : rd_chk

  task automatic chk_decode(input logic sel);
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    chk("ref1", 32'(cfg[pll_cfg_pkg::REF1_LSB +: 8]),
      32'(ref_div_pll1_o));
    chk("ref2", 32'(cfg[pll_cfg_pkg::REF2_LSB +: 8]),
      32'(ref_div_pll2_o));
    chk("ref3", 32'(sel ? cfg[pll_cfg_pkg::REF3_S1_LSB +: 8]
      : cfg[pll_cfg_pkg::REF3_S0_LSB +: 8]),
      32'(ref_div_pll3_o));
    chk("fb a1", 32'(cfg[8 +: 3]), 32'(fb_a_pll1_o));
    chk("fb m1", 32'(cfg[11 +: 8]), 32'(fb_m_pll1_o));
    chk("fb a2", 32'(cfg[32 +: 3]), 32'(fb_a_pll2_o));
    chk("fb m2", 32'(cfg[35 +: 8]), 32'(fb_m_pll2_o));
    chk("fb a3", 32'(cfg[56 +: 3]), 32'(fb_a_pll3_o));
    chk("fb m3", 32'(cfg[59 +: 8]), 32'(fb_m_pll3_o));
  endtask : chk_decode

  task automatic ticks(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock_i);
      src_tick_i <= 4'hf;
    end
    @(posedge clock_i);
    src_tick_i <= 4'h0;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask : ticks

  task automatic chk_ticks(input int lane, input int exp);
    chk("tick count", 32'(exp), 32'(tick_cnt[lane] - snap[lane]));
  endtask : chk_ticks

  task automatic set_sel(input logic s);
    @(posedge clock_i);
    param_set_select_i <= s;
  endtask : set_sel

  initial
  begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    chk("ref1 at reset", 32'h0, 32'(ref_div_pll1_o));
    chk("waitrequest at rest", 32'h1, 32'(avs_waitrequest_o));
    rd_chk("cfg3 at reset", 5'h0c, 32'h0);
    wr(5'h00, 32'ha5f3_075c, 4'hf);
    wr(5'h04, 32'h3ce6_0b5d, 4'hf);
    wr(5'h08, 32'h8157_c2e9, 4'hf);
    // Only lane 1 may change
    wr(5'h00, 32'hffff_6aff, 4'b0010);
    chk_decode(1'b0);
    set_sel(1'b1);
    chk_decode(1'b1);
    set_sel(1'b0);
    chk_decode(1'b0);
    rd_chk("cfg0", 5'h00, cfg[31:0]);
    rd_chk("st ref", 5'h10, {8'h0, cfg[55:48], cfg[31:24], cfg[7:0]});
    rd_chk("st fb", 5'h14, {10'h0, cfg[42:32], cfg[18:8]});
    wr(5'h1c, 32'hffff_ffff, 4'hf);
    rd_chk("unmapped", 5'h1c, 32'h0);
    rd_chk("cfg2", 5'h08, cfg[95:64]);
    // Whole multiples of the ratio leave every counter back at zero
    for (int c = 0; c < 16; c++)
    begin
      wr(5'h0c, {16'h0, {4{4'(c)}}}, 4'hf);
      snap = tick_cnt;
      ticks(2 * int'(RATIO[c]));
      for (int p = 0; p < 4; p++)
        chk_ticks(p, 2);
    end
    wr(5'h0c, 32'h0032_1111, 4'hf);
    set_sel(1'b1);
    repeat (5) @(posedge clock_i);
    snap = tick_cnt;
    ticks(12);
    chk_ticks(0, 6);
    chk_ticks(2, 4);
    chk_ticks(3, 3);
    set_sel(1'b0);
    repeat (5) @(posedge clock_i);
    ticks(1);
    wr(5'h0c, 32'h0800_1111, 4'hf);
    snap = tick_cnt;
    ticks(11);
    chk_ticks(3, 0);
    chk_ticks(0, 6);
    rd_chk("st out", 5'h18,
      {cfg[66:56], 4'h0, cfg[123], cfg[111:96]});
    wr(5'h0c, 32'h0000_1111, 4'hf);
    snap = tick_cnt;
    ticks(1);
    chk_ticks(3, 0);
    ticks(1);
    chk_ticks(3, 1);
    give_verdict();
  end

  initial
  begin
    #(40 * 20000);
    fails++;
    give_verdict();
  end
endmodule : tb_pll_divider_config_decode
